// [amtc_pkg.sv]
package amtc_pkg;
    // Register map: byte addresses on the internal CPU bus
    localparam logic [15:0] AMTC_MODE_ADDR = 16'hff80;
    localparam logic [15:0] AMTC_CHSEL_ADDR = 16'hff81;
    localparam logic [15:0] AMTC_RES_LO_ADDR = 16'hff18;
    localparam logic [15:0] AMTC_RES_HI_ADDR = 16'hff19;
    localparam logic [15:0] AMTC_RES_UP_ADDR = 16'hff1a;
    localparam logic [15:0] AMTC_PDIR_ADDR = 16'hff22;
    localparam logic [15:0] AMTC_PMODE_ADDR = 16'hff84;
    // Mode register fields; write masks and reset values of the writable registers, and other constants
    localparam int AMTC_START_POS = 7;
    localparam int AMTC_TSEL_LSB = 3;
    localparam int AMTC_CMP_POS = 0;
    localparam logic [7:0] AMTC_MODE_WMASK = 8'hb9;
    localparam logic [7:0] AMTC_MODE_RESET = 8'h00;
    localparam logic [7:0] AMTC_CHSEL_WMASK = 8'h03;
    localparam logic [7:0] AMTC_CHSEL_RESET = 8'h00;
    localparam logic [7:0] AMTC_PDIR_WMASK = 8'h0f;
    localparam logic [7:0] AMTC_PDIR_RESET = 8'hff;
    localparam logic [7:0] AMTC_PMODE_WMASK = 8'h0f;
    localparam logic [7:0] AMTC_PMODE_RESET = 8'h00;
    localparam int AMTC_RES_BITS = 10;
    localparam logic [7:0] AMTC_CNT_ONE = 8'h01;

    // CPU access: byte write, or single-bit write selected by bitSel
    typedef struct packed {
        logic write;
        logic read;
        logic bitOp;
        logic [2:0] bitSel;
        logic [15:0] addr;
        logic [7:0] wdata;
    } amtc_bus_type;

    // Analog front end controls
    typedef struct packed {
        logic compEnable;
        logic sampleHold;
        logic [9:0] dacCode;
        logic [1:0] channel;
    } amtc_afe_type;

    // Sampling and total conversion time in peripheral clocks per code
    function automatic logic [7:0] amtc_sample_clks(input logic [2:0] code);
        unique case (code)
            3'b000: return 8'd12;
            3'b001: return 8'd24;
            3'b010: return 8'd48;
            3'b011: return 8'd88;
            3'b100: return 8'd24;
            3'b101: return 8'd48;
            3'b110: return 8'd96;
            default: return 8'd176;
        endcase
    endfunction : amtc_sample_clks

    function automatic logic [7:0] amtc_conv_clks(input logic [2:0] code);
        unique case (code)
            3'b000: return 8'd36;
            3'b001: return 8'd48;
            3'b010: return 8'd72;
            3'b011: return 8'd112;
            3'b100: return 8'd72;
            3'b101: return 8'd96;
            3'b110: return 8'd144;
            default: return 8'd224;
        endcase
    endfunction : amtc_conv_clks

    // Byte or bit write merged into an old value, reserved bits forced
    function automatic logic [7:0] amtc_merge(input amtc_bus_type b, input logic [7:0] old,
                                              input logic [7:0] wmask, input logic [7:0] fixed);
        logic [7:0] v;
        v = old;
        if (b.bitOp) begin
            v[b.bitSel] = b.wdata[0];
        end else begin
            v = b.wdata;
        end
        return (v & wmask) | (fixed & ~wmask);
    endfunction : amtc_merge
endpackage : amtc_pkg

// [amtc_sar_engine.sv]
`timescale 1ns/100ps
`default_nettype none
module amtc_sar_engine
    import amtc_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic run,
    input wire logic [2:0] timeSel,
    input wire logic compOut,
    output logic sampleHold,
    output logic [9:0] dacCode,
    output logic done,
    output logic [9:0] result
);
    typedef enum logic [2:0] {
        SAMPLE = 3'b001,
        COMPARE = 3'b010,
        FINISH = 3'b100
    } amtc_state_type;

    amtc_state_type state;
    logic [7:0] cycleCnt;
    logic [3:0] bitIdx;
    logic [9:0] sar;
    logic [7:0] sampleLen;
    logic [7:0] compareLen;
    logic [7:0] trialLen;
    logic [7:0] lastLen;
    logic [7:0] stepEnd;

    // Compare phase: nine equal bit trials, the LSB trial takes the remainder
    assign sampleLen = amtc_sample_clks(timeSel);
    assign compareLen = amtc_conv_clks(timeSel) - sampleLen;
    assign trialLen = compareLen / 8'd10;
    assign lastLen = compareLen - 8'd9 * trialLen;
    assign stepEnd = ((bitIdx == 4'd0) ? lastLen : trialLen) - AMTC_CNT_ONE;

    // Sample, then walk bits MSB first; repeats while running
    always_ff @(posedge clock) begin
        done <= 1'b0;
        if (srst || !run) begin
            state <= SAMPLE;
            cycleCnt <= '0;
            bitIdx <= 4'd9;
            sar <= '0;
        end else begin
            cycleCnt <= cycleCnt + AMTC_CNT_ONE;
            unique case (state)
                SAMPLE: begin
                    // DAC parked at mid-scale so the slow comparator path settles early
                    sar <= 10'h200;
                    if (cycleCnt == sampleLen - AMTC_CNT_ONE) begin
                        state <= COMPARE;
                        cycleCnt <= '0;
                        bitIdx <= 4'd9;
                    end
                end
                // Comparator answer lags about five clocks; short trials see the prior trial
                COMPARE: if (cycleCnt == stepEnd) begin
                    cycleCnt <= '0;
                    if (!compOut) sar[bitIdx] <= 1'b0;
                    if (bitIdx == 4'd0) begin
                        state <= FINISH;
                    end else begin
                        sar[bitIdx - 4'd1] <= 1'b1;
                        bitIdx <= bitIdx - 4'd1;
                    end
                end
                FINISH: begin
                    done <= 1'b1;
                    result <= sar;
                    state <= SAMPLE;
                    cycleCnt <= '0;
                end
            endcase
        end
    end

    assign sampleHold = run && state == SAMPLE;
    assign dacCode = sar;

    convDone_a: assert property (@(posedge clock) disable iff (srst)
        done |-> $past(state) == FINISH && result == $past(sar))
        else $error("done without finish");
endmodule : amtc_sar_engine
`default_nettype wire

// [amtc_mode_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module amtc_mode_ctrl
    import amtc_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire amtc_bus_type bus,
    output logic [7:0] rdata,
    input wire logic compOut,
    output amtc_afe_type afe,
    output logic conversion_done_irq,
    output logic [3:0] port2_direction,
    output logic [3:0] port2_mode_control
);
    logic [7:0] converter_mode_control;
    logic [7:0] input_channel_select;
    logic [7:0] portDirReg;
    logic [7:0] portModeReg;
    logic [9:0] result_ten_bit;
    logic [9:0] sarResult;
    logic sarDone;
    logic sampleHold;
    logic [9:0] dacCode;
    logic conversion_start_bit;
    logic comparator_enable_bit;
    logic [2:0] timeSel;
    logic compSync1;
    logic compSync2;
    logic compSync3;
    logic compLevel;

    assign conversion_start_bit = converter_mode_control[AMTC_START_POS];
    assign comparator_enable_bit = converter_mode_control[AMTC_CMP_POS];
    assign timeSel = converter_mode_control[AMTC_TSEL_LSB +: 3];

    // Mode register: bit and byte writes, fixed zero bits never stored
    always_ff @(posedge clock) begin
        if (srst) begin
            converter_mode_control <= AMTC_MODE_RESET;
        end else if (bus.write && bus.addr == AMTC_MODE_ADDR) begin
            converter_mode_control <= amtc_merge(bus, converter_mode_control,
                                                 AMTC_MODE_WMASK, 8'h00);
        end
    end

    // Companion registers: channel and port setup
    always_ff @(posedge clock) begin
        if (srst) begin
            input_channel_select <= AMTC_CHSEL_RESET;
            portDirReg <= AMTC_PDIR_RESET;
            portModeReg <= AMTC_PMODE_RESET;
        end else if (bus.write) begin
            if (bus.addr == AMTC_CHSEL_ADDR) begin
                input_channel_select <= amtc_merge(bus, input_channel_select,
                                                   AMTC_CHSEL_WMASK, 8'h00);
            end
            if (bus.addr == AMTC_PDIR_ADDR) begin
                portDirReg <= amtc_merge(bus, portDirReg, AMTC_PDIR_WMASK, 8'hf0);
            end
            if (bus.addr == AMTC_PMODE_ADDR) begin
                portModeReg <= amtc_merge(bus, portModeReg, AMTC_PMODE_WMASK, 8'h00);
            end
        end
    end

    // Comparator output is asynchronous to us; three stages, agree on last two
    always_ff @(posedge clock) begin
        if (srst) begin
            compSync1 <= 1'b0;
            compSync2 <= 1'b0;
            compSync3 <= 1'b0;
            compLevel <= 1'b0;
        end else begin
            compSync1 <= compOut;
            compSync2 <= compSync1;
            compSync3 <= compSync2;
            if (compSync2 == compSync3) compLevel <= compSync3;
        end
    end

    amtc_sar_engine sarEngine (
        .clock(clock),
        .srst(srst),
        .run(conversion_start_bit),
        .timeSel(timeSel),
        .compOut(compLevel),
        .sampleHold(sampleHold),
        .dacCode(dacCode),
        .done(sarDone),
        .result(sarResult)
    );

    // Result latch; undefined after reset in hardware, zero here for clean sim
    always_ff @(posedge clock) begin
        if (srst) begin
            result_ten_bit <= '0;
        end else if (sarDone) begin
            result_ten_bit <= sarResult;
        end
    end

    // Interrupt is a one-cycle pulse per finished conversion
    always_ff @(posedge clock) begin
        if (srst) conversion_done_irq <= 1'b0;
        else conversion_done_irq <= sarDone;
    end

    // Front-end drive; comparator powered by enable or start
    always_ff @(posedge clock) begin
        if (srst) begin
            afe <= '0;
        end else begin
            afe.compEnable <= comparator_enable_bit || conversion_start_bit;
            afe.sampleHold <= sampleHold;
            afe.dacCode <= dacCode;
            afe.channel <= input_channel_select[1:0];
        end
    end

    // Port outputs registered from their control registers
    always_ff @(posedge clock) begin
        if (srst) begin
            port2_direction <= AMTC_PDIR_RESET[3:0];
            port2_mode_control <= AMTC_PMODE_RESET[3:0];
        end else begin
            port2_direction <= portDirReg[3:0];
            port2_mode_control <= portModeReg[3:0];
        end
    end

    // Read data registered: answer one cycle after the read strobe
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata <= '0;
        end else if (bus.read) begin
            unique case (bus.addr)
                AMTC_MODE_ADDR: rdata <= converter_mode_control;
                AMTC_CHSEL_ADDR: rdata <= input_channel_select;
                AMTC_RES_LO_ADDR: rdata <= result_ten_bit[7:0];
                AMTC_RES_HI_ADDR: rdata <= {6'b0, result_ten_bit[9:8]};
                AMTC_RES_UP_ADDR: rdata <= result_ten_bit[9:2];
                AMTC_PDIR_ADDR: rdata <= portDirReg;
                AMTC_PMODE_ADDR: rdata <= portModeReg;
                default: rdata <= '0;
            endcase
        end
    end

    // Register file checks
    modeReset_a: assert property (@(posedge clock)
        srst |=> converter_mode_control == AMTC_MODE_RESET)
        else $error("mode not cleared by reset");
    modeRead_a: assert property (@(posedge clock) disable iff (srst)
        bus.read && bus.addr == AMTC_MODE_ADDR |=> rdata == $past(converter_mode_control))
        else $error("mode readback wrong");
    reservedZero_a: assert property (@(posedge clock) disable iff (srst)
        (converter_mode_control & ~AMTC_MODE_WMASK) == 8'h00)
        else $error("reserved mode bit set");
    byteWrite_a: assert property (@(posedge clock) disable iff (srst)
        bus.write && !bus.bitOp && bus.addr == AMTC_MODE_ADDR
        |=> converter_mode_control == ($past(bus.wdata) & AMTC_MODE_WMASK))
        else $error("byte write lost");
    chselReserved_a: assert property (@(posedge clock) disable iff (srst)
        (input_channel_select & ~AMTC_CHSEL_WMASK) == 8'h00)
        else $error("reserved channel bit set");
    portDirFixed_a: assert property (@(posedge clock) disable iff (srst)
        portDirReg[7:4] == 4'hf)
        else $error("fixed port direction bit cleared");

    // Conversion flow checks; the latch is one cycle behind the engine's finish
    compDrive_a: assert property (@(posedge clock) disable iff (srst)
        $past(comparator_enable_bit || conversion_start_bit) && !$past(srst)
        |-> afe.compEnable)
        else $error("comparator not enabled");
    compStop_a: assert property (@(posedge clock) disable iff (srst)
        !comparator_enable_bit && !conversion_start_bit |=> !afe.compEnable)
        else $error("comparator left running");
    startSample_a: assert property (@(posedge clock) disable iff (srst)
        $rose(conversion_start_bit) |=> afe.sampleHold)
        else $error("sampling did not follow start");
    stopNoSample_a: assert property (@(posedge clock) disable iff (srst)
        !conversion_start_bit |-> !sampleHold)
        else $error("sampling while stopped");
    stopNoIrq_a: assert property (@(posedge clock) disable iff (srst)
        !conversion_start_bit [*3] |-> !conversion_done_irq)
        else $error("interrupt while stopped");
    irqPulse_a: assert property (@(posedge clock) disable iff (srst)
        conversion_done_irq |=> !conversion_done_irq)
        else $error("interrupt longer than one cycle");
    irqResult_a: assert property (@(posedge clock) disable iff (srst)
        conversion_done_irq |-> result_ten_bit == $past(sarResult))
        else $error("result not latched");
    resultHold_a: assert property (@(posedge clock) disable iff (srst)
        !sarDone |=> $stable(result_ten_bit))
        else $error("result changed without finish");
    firstDone_a: assert property (@(posedge clock) disable iff (srst)
        $rose(conversion_start_bit) && timeSel == 3'b000
        |-> !sarDone [*8])
        else $error("conversion too fast");
    tselStable_a: assert property (@(posedge clock) disable iff (srst)
        conversion_start_bit && $past(conversion_start_bit) |-> $stable(timeSel))
        else $error("timing changed while running");

    // Scenario coverage
    convDoneCov_c: cover property (@(posedge clock) conversion_done_irq);
    bitWriteCov_c: cover property (@(posedge clock) bus.write && bus.bitOp);
    waitModeCov_c: cover property (@(posedge clock)
        comparator_enable_bit && !conversion_start_bit);
    stopCov_c: cover property (@(posedge clock) $fell(conversion_start_bit));
endmodule : amtc_mode_ctrl
`default_nettype wire

// [amtc_afe_model.sv]
`timescale 1ns/100ps
`default_nettype none
module amtc_afe_model
    import amtc_pkg::*;
(
    input wire logic clock,
    input wire amtc_afe_type afe,
    input wire logic [9:0] level,
    output logic compOut
);
    logic [9:0] held = 10'h000;
    logic idle = 1'b0;
    // Hold capacitor follows the pin only while sampling
    always @(posedge clock) begin
        if (afe.sampleHold) begin
            held <= level;
        end
        idle <= ~idle;
    end
    // A stopped comparator has no settled answer, so it wanders
    always_comb begin
        compOut = afe.compEnable ? (held >= afe.dacCode) : idle;
    end
endmodule : amtc_afe_model
`default_nettype wire

// [adc_mode_timing_control_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module adc_mode_timing_control_bench import amtc_pkg::*; ;
    typedef struct packed {
        logic [15:0] a;
        logic bop;
        logic [2:0] sel;
        logic [7:0] d;
        logic [7:0] e;
    } amtc_row_type;
    logic clock;
    logic srst;
    amtc_bus_type bus;
    logic [7:0] rdata;
    logic compOut;
    amtc_afe_type afe;
    logic doneIrq;
    logic [3:0] portDir;
    logic [3:0] portMode;
    logic [9:0] level;
    int badCount = 0;
    int nCompared = 0;
    int cyc = 0;
    int n;
    int m;
    int k;
    int smp[8] = '{12, 24, 48, 88, 24, 48, 96, 176};
    int conv[8] = '{36, 48, 72, 112, 72, 96, 144, 224};
    // Reserved bits written as ones on purpose to see them refused
    amtc_row_type rows[10] = '{
        '{16'hff80, 1'b0, 3'd0, 8'h7f, 8'h39}, '{16'hff80, 1'b1, 3'd6, 8'h01, 8'h39},
        '{16'hff80, 1'b1, 3'd0, 8'h00, 8'h38}, '{16'hff80, 1'b0, 3'd0, 8'h00, 8'h00},
        '{16'hff81, 1'b0, 3'd0, 8'hff, 8'h03}, '{16'hff22, 1'b0, 3'd0, 8'h00, 8'hf0},
        '{16'hff22, 1'b1, 3'd2, 8'h01, 8'hf4}, '{16'hff84, 1'b0, 3'd0, 8'hff, 8'h0f},
        '{16'hff84, 1'b1, 3'd1, 8'h00, 8'h0d}, '{16'hff90, 1'b0, 3'd0, 8'hff, 8'h00}};

    amtc_mode_ctrl dut (.clock(clock), .srst(srst), .bus(bus), .rdata(rdata),
        .compOut(compOut), .afe(afe), .conversion_done_irq(doneIrq),
        .port2_direction(portDir), .port2_mode_control(portMode));
    amtc_afe_model front (.clock(clock), .afe(afe), .level(level), .compOut(compOut));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic close_out;
        $display("Compared %0d, mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One bus access held over exactly one sampling edge
    task automatic acc(input logic wr, input logic bop, input logic [2:0] sel,
                       input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{write: wr, read: !wr, bitOp: bop, bitSel: sel, addr: a, wdata: d};
        @(posedge clock);
        bus <= '0;
    endtask : acc

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        acc(1'b0, 1'b0, 3'd0, a, 8'h00);
        @(posedge clock);
        #1 chk({8'h00, rdata}, {8'h00, e});
    endtask : rd

    // Hang guard: whole run needs well under this many cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 30000) begin
            badCount++;
            close_out();
        end
    end

    initial begin
        srst = 1'b1;
        bus = '0;
        level = 10'h000;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        rd(16'hff80, 8'h00);
        rd(16'hff81, 8'h00);
        rd(16'hff22, 8'hff);
        rd(16'hff84, 8'h00);
        chk({12'h000, afe.compEnable, afe.sampleHold, doneIrq, 1'b0}, 16'h0000);
        foreach (rows[i]) begin
            acc(1'b1, rows[i].bop, rows[i].sel, rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        chk({8'h00, portDir, portMode}, 16'h004d);
        acc(1'b1, 1'b0, 3'd0, 16'hff80, 8'h01);
        @(posedge clock);
        #1 chk({15'h0, afe.compEnable}, 16'h0001);
        chk({14'h0, afe.channel}, 16'h0003);
        acc(1'b1, 1'b0, 3'd0, 16'hff80, 8'h00);
        @(posedge clock);
        #1 chk({15'h0, afe.compEnable}, 16'h0000);
        // Every timing code: sampling length, finish time, result copy
        for (int c = 0; c < 8; c++) begin
            level <= c[0] ? 10'h000 : 10'h3ff;
            // Timing field set while stopped, reserved bits zero, then start alone
            acc(1'b1, 1'b0, 3'd0, 16'hff80, {2'b00, c[2:0], 3'b000});
            acc(1'b1, 1'b1, 3'd7, 16'hff80, 8'h01);
            k = 0;
            while (afe.sampleHold !== 1'b1 && k < 50) begin @(posedge clock); #1 k++; end
            n = 0;
            while (afe.sampleHold === 1'b1 && n < 300) begin @(posedge clock); #1 n++; end
            m = 0;
            while (doneIrq !== 1'b1 && m < 400) begin @(posedge clock); #1 m++; end
            chk(n[15:0], smp[c][15:0]);
            chk({15'h0, m >= conv[c] - smp[c] && m <= conv[c] - smp[c] + 3}, 16'h1);
            rd(16'hff1a, level[9:2]);
            rd(16'hff18, level[7:0]);
            rd(16'hff19, {6'h00, level[9:8]});
            acc(1'b1, 1'b0, 3'd0, 16'hff80, 8'h00);
        end
        // Start by bit write, then stop mid-conversion: no completion may follow
        acc(1'b1, 1'b1, 3'd7, 16'hff80, 8'h01);
        rd(16'hff80, 8'h80);
        acc(1'b1, 1'b1, 3'd7, 16'hff80, 8'h00);
        k = 0;
        repeat (300) begin
            @(posedge clock);
            #1 k += (doneIrq === 1'b1 || afe.sampleHold === 1'b1);
        end
        chk(k[15:0], 16'h0000);
        // Reset in mid-run restores the mode register and port direction to their reset values
        acc(1'b1, 1'b0, 3'd0, 16'hff80, 8'hb9);
        acc(1'b1, 1'b0, 3'd0, 16'hff22, 8'h00);
        repeat (20) @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        rd(16'hff80, 8'h00);
        chk({12'h000, portDir}, 16'h000f);
        close_out();
    end
endmodule : adc_mode_timing_control_bench
`default_nettype wire
